// >>> txmc_top.sv
`timescale 1ns/10ps
`include "txmc_defines.svh"
//
// Behaviour
// [RULE_01] amplifier off when level field is zero, on for any other value
// [RULE_02] level one gives maximum power; seven nonzero power steps
// [RULE_03] bypass bit routes around amplifier while level field still sets power
// [RULE_04] mode 00 uses waveform modulator, 10 uses two divider sets; 01/11 unused
// [RULE_05] two-divider mode: data zero uses set zero, data one uses set one
// [RULE_06] two-divider mode: floating data pin selects divider set zero
// [RULE_07] modulator mode: floating pin locks LO, high/low shift carrier up/down
// [RULE_08] data pin is input while transmitting, output while receiving
// [RULE_09] host keeps pin undriven until lock and amplifier on
// [RULE_10] host Manchester: zero sent as 10, one as 01
// [RULE_11] host three-to-four code maps six inputs to balanced words
// [RULE_12] host alternates A and B words for 000 and 111 by one flag
// [RULE_13] modulator clock is crystal over divider times two to seven minus scale
// [RULE_14] each waveform edge spans four modulator periods with unequal currents
// [RULE_15] host sets modulator clock at least eight times the bit rate

module txmc_top
   import txmc_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   // three-wire serial register port
   input  wire logic             ser_clk_i,
   input  wire logic             ser_latch_i,
   input  wire logic             ser_data_i,
   output logic                  ser_data_o,
   output logic                  ser_data_oe_o,
   // bidirectional data pin
   input  wire logic             tx_rx_data_pin_i,
   input  wire logic             tx_rx_data_pin_float_i,
   output logic                  tx_rx_data_pin_o,
   output logic                  tx_rx_data_pin_oe_o,
   // transceiver state
   input  wire logic             transmit_mode_i,
   input  wire logic             rx_data_i,
   input  wire logic             pll_lock_i,
   // analogue controls
   output txmc_pkg::txmc_amp_t   amp_o,
   output txmc_pkg::txmc_freq_t  freq_o,
   output logic                  modclk_tick_o,
   output logic                  mod_charging_o,
   output logic                  mod_discharging_o,
   output logic [1:0]            mod_step_o,
   output logic [1:0]            mod_current_weight_o,
   output logic                  mod_select_illegal_o
);
   import txmc_pkg::*;

   // pin synchronisers
   logic [1:0] sck_s_q, sle_s_q, sdi_s_q, dpin_s_q, dflt_s_q;
   logic       sck_prev_q, sle_prev_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sck_s_q    <= 2'h0;
         sle_s_q    <= 2'h0;
         sdi_s_q    <= 2'h0;
         dpin_s_q   <= 2'h0;
         dflt_s_q   <= 2'h3;
         sck_prev_q <= 1'b0;
         sle_prev_q <= 1'b0;
      end else begin
         sck_s_q    <= {sck_s_q[0], ser_clk_i};
         sle_s_q    <= {sle_s_q[0], ser_latch_i};
         sdi_s_q    <= {sdi_s_q[0], ser_data_i};
         dpin_s_q   <= {dpin_s_q[0], tx_rx_data_pin_i};
         dflt_s_q   <= {dflt_s_q[0], tx_rx_data_pin_float_i};
         sck_prev_q <= sck_s_q[1];
         sle_prev_q <= sle_s_q[1];
      end
   end

   logic sck_rise, sck_fall, sle_rise;
   assign sck_rise = sck_s_q[1] & ~sck_prev_q;
   assign sck_fall = ~sck_s_q[1] & sck_prev_q;
   assign sle_rise = sle_s_q[1] & ~sle_prev_q;

   // register file
   logic [7:0] reg_main_q, reg_main_d;
   logic [7:0] reg_modrssi_q, reg_modrssi_d;
   logic [7:0] reg_pumpbyp_q, reg_pumpbyp_d;
   logic [7:0] reg_modfilt_q, reg_modfilt_d;
   logic [7:0] reg_modatt_q, reg_modatt_d;
   logic [7:0] reg_clkscale_q, reg_clkscale_d;
   logic [7:0] reg_rateref_q, reg_rateref_d;

   // serial shifter: frame is address(7), read flag, data(8), msb first
   logic [15:0] shift_q, shift_d;
   logic [4:0]  bits_q, bits_d;
   logic        rd_active_q, rd_active_d;
   logic [7:0]  rd_shift_q, rd_shift_d;
   logic        sdo_q, sdo_d;

   function automatic logic [7:0] txmc_read(input logic [6:0] a,
                                             input logic [7:0] r0, input logic [7:0] r1,
                                             input logic [7:0] r2, input logic [7:0] r4,
                                             input logic [7:0] r5, input logic [7:0] r6,
                                             input logic [7:0] r7);
      unique case (a)
         `TXMC_ADDR_MAIN:     txmc_read = r0;
         `TXMC_ADDR_MODRSSI:  txmc_read = {r1[7:6], 2'b00, r1[3:0]};
         `TXMC_ADDR_PUMPBYP:  txmc_read = {r2[7:6], 1'b0, r2[4:0]};
         `TXMC_ADDR_MODFILT:  txmc_read = r4;
         `TXMC_ADDR_MODATT:   txmc_read = {4'h1, r5[3:0]};
         `TXMC_ADDR_CLKSCALE: txmc_read = {1'b0, r6[6:0]};
         `TXMC_ADDR_RATEREF:  txmc_read = r7;
         default:             txmc_read = 8'h00;
      endcase
   endfunction

   always_comb begin
      shift_d        = shift_q;
      bits_d         = bits_q;
      rd_active_d    = rd_active_q;
      rd_shift_d     = rd_shift_q;
      sdo_d          = sdo_q;
      reg_main_d     = reg_main_q;
      reg_modrssi_d  = reg_modrssi_q;
      reg_pumpbyp_d  = reg_pumpbyp_q;
      reg_modfilt_d  = reg_modfilt_q;
      reg_modatt_d   = reg_modatt_q;
      reg_clkscale_d = reg_clkscale_q;
      reg_rateref_d  = reg_rateref_q;
      if (sck_rise && !rd_active_q && bits_q < `TXMC_FRAME_BITS) begin
         shift_d = {shift_q[14:0], sdi_s_q[1]};
         bits_d  = bits_q + 5'h1;
         // after address and read flag, a read takes over the data phase
         if (bits_q == 5'h7 && sdi_s_q[1]) begin
            rd_active_d = 1'b1;
            rd_shift_d  = txmc_read(shift_q[6:0], reg_main_q, reg_modrssi_q,
                                    reg_pumpbyp_q, reg_modfilt_q, reg_modatt_q,
                                    reg_clkscale_q, reg_rateref_q);
         end
      end
      if (rd_active_q && sck_fall) begin
         sdo_d      = rd_shift_q[7];
         rd_shift_d = {rd_shift_q[6:0], 1'b0};
      end
      if (sle_rise) begin
         if (!rd_active_q && bits_q == `TXMC_FRAME_BITS) begin
            unique case (shift_q[15:9])
               `TXMC_ADDR_MAIN:     reg_main_d     = shift_q[7:0];
               `TXMC_ADDR_MODRSSI:  reg_modrssi_d  = shift_q[7:0];
               `TXMC_ADDR_PUMPBYP:  reg_pumpbyp_d  = shift_q[7:0];
               `TXMC_ADDR_MODFILT:  reg_modfilt_d  = shift_q[7:0];
               `TXMC_ADDR_MODATT:   reg_modatt_d   = shift_q[7:0];
               `TXMC_ADDR_CLKSCALE: reg_clkscale_d = shift_q[7:0];
               `TXMC_ADDR_RATEREF:  reg_rateref_d  = shift_q[7:0];
               default: ;
            endcase
         end
         bits_d      = 5'h0;
         rd_active_d = 1'b0;
         sdo_d       = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_q        <= 16'h0000;
         bits_q         <= 5'h00;
         rd_active_q    <= 1'b0;
         rd_shift_q     <= 8'h00;
         sdo_q          <= 1'b0;
         reg_main_q     <= `TXMC_RST_REG;
         reg_modrssi_q  <= `TXMC_RST_REG;
         reg_pumpbyp_q  <= `TXMC_RST_REG;
         reg_modfilt_q  <= `TXMC_RST_REG;
         reg_modatt_q   <= `TXMC_RST_MODATT;
         reg_clkscale_q <= `TXMC_RST_REG;
         reg_rateref_q  <= `TXMC_RST_REG;
      end else begin
         shift_q        <= shift_d;
         bits_q         <= bits_d;
         rd_active_q    <= rd_active_d;
         rd_shift_q     <= rd_shift_d;
         sdo_q          <= sdo_d;
         reg_main_q     <= reg_main_d;
         reg_modrssi_q  <= reg_modrssi_d;
         reg_pumpbyp_q  <= reg_pumpbyp_d;
         reg_modfilt_q  <= reg_modfilt_d;
         reg_modatt_q   <= reg_modatt_d;
         reg_clkscale_q <= reg_clkscale_d;
         reg_rateref_q  <= reg_rateref_d;
      end
   end

   assign ser_data_o    = sdo_q;
   assign ser_data_oe_o = rd_active_q;

   // decoded fields
   logic [2:0] amp_level;
   logic       amp_bypass;
   txmc_mod_t  mod_sel;
   logic [2:0] modclk_scale;
   logic [5:0] ref_div;
   assign amp_level    = reg_main_q[`TXMC_AMP_LEVEL_MSB:`TXMC_AMP_LEVEL_LSB];
   assign amp_bypass   = reg_pumpbyp_q[`TXMC_AMP_BYPASS_BIT];
   assign mod_sel      = txmc_mod_t'(reg_modrssi_q[`TXMC_MOD_SEL_MSB:`TXMC_MOD_SEL_LSB]);
   assign modclk_scale = reg_clkscale_q[`TXMC_MODCLK_MSB:`TXMC_MODCLK_LSB];
   assign ref_div      = reg_rateref_q[`TXMC_REFK_MSB:`TXMC_REFK_LSB];

   txmc_pin_t pin;
   assign pin.floating = dflt_s_q[1];
   assign pin.level    = dpin_s_q[1];

   // amplifier and frequency selection
   txmc_amp_t  amp_d, amp_q;
   txmc_freq_t freq_d, freq_q;
   logic       pin_o_d, pin_o_q, pin_oe_d, pin_oe_q, illegal_d, illegal_q;

   always_comb begin
      amp_d.pa_on     = (amp_level != `TXMC_AMP_OFF); // RULE_01
      amp_d.max_power = (amp_level == `TXMC_AMP_MAX); // RULE_02
      amp_d.pa_level  = amp_level;                    // RULE_03
      amp_d.pa_bypass = amp_bypass;                   // RULE_03
      freq_d          = '0;
      illegal_d       = 1'b0;
      unique case (mod_sel)
         TXMC_MOD_LOOP: begin // RULE_04
            // floating pin holds the receive LO frequency
            freq_d.lock_lo    = pin.floating;                // RULE_07
            freq_d.shift_up   = !pin.floating && pin.level;  // RULE_07
            freq_d.shift_down = !pin.floating && !pin.level; // RULE_07
         end
         TXMC_MOD_TWODIV: begin // RULE_04
            freq_d.use_set1 = !pin.floating && pin.level; // RULE_05 RULE_06
         end
         // unused codes flagged and fall back to divider set zero
         TXMC_MOD_RSV1, TXMC_MOD_RSV3: illegal_d = 1'b1; // RULE_04
      endcase
      pin_oe_d = !transmit_mode_i; // RULE_08
      pin_o_d  = transmit_mode_i ? 1'b0 : rx_data_i;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         amp_q     <= '0;
         freq_q    <= '0;
         pin_o_q   <= 1'b0;
         pin_oe_q  <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         amp_q     <= amp_d;
         freq_q    <= freq_d;
         pin_o_q   <= pin_o_d;
         pin_oe_q  <= pin_oe_d;
         illegal_q <= illegal_d;
      end
   end

   assign amp_o                = amp_q;
   assign freq_o               = freq_q;
   assign tx_rx_data_pin_o     = pin_o_q;
   assign tx_rx_data_pin_oe_o  = pin_oe_q;
   assign mod_select_illegal_o = illegal_q;

   // modulator clock: period = ref_div * 2^(7 - scale) core clocks
   logic [12:0] mc_cnt_q, mc_cnt_d;
   logic [12:0] mc_period;
   logic        mc_tick_q, mc_tick_d;
   assign mc_period = 13'(ref_div) << (`TXMC_SCALE_TOP - modclk_scale); // RULE_13

   always_comb begin
      mc_cnt_d  = mc_cnt_q + 13'h1;
      mc_tick_d = 1'b0;
      // zero divider stops the clock rather than run at full rate
      if (ref_div == 6'h00) begin
         mc_cnt_d = 13'h0;
      end else if (mc_cnt_q >= mc_period - 13'h1) begin // RULE_13
         mc_cnt_d  = 13'h0;
         mc_tick_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mc_cnt_q  <= 13'h0;
         mc_tick_q <= 1'b0;
      end else begin
         mc_cnt_q  <= mc_cnt_d;
         mc_tick_q <= mc_tick_d;
      end
   end

   assign modclk_tick_o = mc_tick_q;

   // edges only shaped in modulator mode while transmitting a driven pin
   txmc_edge_shaper u_shaper (
      .core_clk_i       (core_clk_i),
      .reset_n_i        (reset_n_i),
      .mod_tick_i       (mc_tick_q),
      .enable_i         (transmit_mode_i && mod_sel == TXMC_MOD_LOOP && !pin.floating),
      .target_i         (pin.level),
      .charging_o       (mod_charging_o),
      .discharging_o    (mod_discharging_o),
      .step_o           (mod_step_o),
      .current_weight_o (mod_current_weight_o)
   );
endmodule

// >>> txmc_defines.svh
`ifndef TXMC_DEFINES_SVH
`define TXMC_DEFINES_SVH

// register offsets (7-bit address space)
`define TXMC_ADDR_MAIN      7'h00
`define TXMC_ADDR_MODRSSI   7'h01
`define TXMC_ADDR_PUMPBYP   7'h02
`define TXMC_ADDR_MODFILT   7'h04
`define TXMC_ADDR_MODATT    7'h05
`define TXMC_ADDR_CLKSCALE  7'h06
`define TXMC_ADDR_RATEREF   7'h07

// field positions
`define TXMC_AMP_LEVEL_MSB  6
`define TXMC_AMP_LEVEL_LSB  4
`define TXMC_MOD_SEL_MSB    7
`define TXMC_MOD_SEL_LSB    6
`define TXMC_AMP_BYPASS_BIT 4
`define TXMC_MODCLK_MSB     6
`define TXMC_MODCLK_LSB     4
`define TXMC_REFK_MSB       5
`define TXMC_REFK_LSB       0

// reset values
`define TXMC_RST_REG        8'h00
`define TXMC_RST_MODATT     8'h10

// levels and codes
`define TXMC_AMP_OFF        3'h0
`define TXMC_AMP_MAX        3'h1
`define TXMC_SCALE_TOP      3'h7

// edge shaping: four modulator clock periods per edge
`define TXMC_EDGE_PERIODS   3'h4

// serial frame: 7 address bits, rw bit, 8 data bits
`define TXMC_FRAME_BITS     5'h10

`endif

// >>> txmc_pkg.sv
package txmc_pkg;
   typedef enum logic [1:0] {
      TXMC_MOD_LOOP  = 2'b00,
      TXMC_MOD_RSV1  = 2'b01,
      TXMC_MOD_TWODIV = 2'b10,
      TXMC_MOD_RSV3  = 2'b11
   } txmc_mod_t;

   typedef enum logic [1:0] {
      TXMC_SH_IDLE = 2'b00,
      TXMC_SH_RISE = 2'b01,
      TXMC_SH_FALL = 2'b10
   } txmc_shape_state_t;

   // data pin seen as three levels
   typedef struct packed {
      logic floating;
      logic level;
   } txmc_pin_t;

   typedef struct packed {
      logic       pa_on;
      logic       pa_bypass;
      logic [2:0] pa_level;
      logic       max_power;
   } txmc_amp_t;

   typedef struct packed {
      logic       use_set1;
      logic       lock_lo;
      logic       shift_up;
      logic       shift_down;
   } txmc_freq_t;
endpackage

// >>> txmc_edge_shaper.sv
`timescale 1ns/10ps
`include "txmc_defines.svh"

module txmc_edge_shaper
   import txmc_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // control
   input  wire logic       mod_tick_i,
   input  wire logic       enable_i,
   input  wire logic       target_i,
   // shaped output
   output logic            charging_o,
   output logic            discharging_o,
   output logic [1:0]      step_o,
   output logic [1:0]      current_weight_o
);
   import txmc_pkg::*;

   txmc_shape_state_t state_q, state_d;
   logic [2:0]        cnt_q, cnt_d;
   logic              level_q, level_d;
   logic [1:0]        weight_d;

   // unequal currents over the four periods soften the spectrum
   function automatic logic [1:0] txmc_weight(input logic [2:0] idx);
      unique case (idx)
         3'h0:    txmc_weight = 2'h1;
         3'h1:    txmc_weight = 2'h3;
         3'h2:    txmc_weight = 2'h3;
         default: txmc_weight = 2'h1;
      endcase
   endfunction

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      level_d  = level_q;
      weight_d = 2'h0;
      unique case (state_q)
         TXMC_SH_IDLE: begin
            if (enable_i && mod_tick_i && target_i != level_q) begin
               state_d = target_i ? TXMC_SH_RISE : TXMC_SH_FALL;
               cnt_d   = 3'h0;
            end
         end
         TXMC_SH_RISE, TXMC_SH_FALL: begin
            if (mod_tick_i) begin
               if (cnt_q == `TXMC_EDGE_PERIODS - 3'h1) begin // RULE_14
                  state_d = TXMC_SH_IDLE;
                  level_d = (state_q == TXMC_SH_RISE);
               end else begin
                  cnt_d = cnt_q + 3'h1;
               end
            end
         end
         default: state_d = TXMC_SH_IDLE;
      endcase
      // weight of the period now driven, not the one just left
      if (state_d != TXMC_SH_IDLE) begin
         weight_d = txmc_weight(cnt_d); // RULE_14
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q          <= TXMC_SH_IDLE;
         cnt_q            <= 3'h0;
         level_q          <= 1'b0;
         current_weight_o <= 2'h0;
      end else begin
         state_q          <= state_d;
         cnt_q            <= cnt_d;
         level_q          <= level_d;
         current_weight_o <= weight_d;
      end
   end

   assign charging_o    = (state_q == TXMC_SH_RISE);
   assign discharging_o = (state_q == TXMC_SH_FALL);
   assign step_o        = cnt_q[1:0];
endmodule

// >>> txmc_top_props.sv
`timescale 1ns/10ps
module txmc_top_props
   import txmc_pkg::*;
(
   // clock and reset
   input wire logic       core_clk_i,
   input wire logic       reset_n_i,
   // serial port
   input wire logic       ser_clk_i,
   input wire logic       ser_latch_i,
   input wire logic       ser_data_i,
   input wire logic       ser_data_o,
   input wire logic       ser_data_oe_o,
   // data pin and mode
   input wire logic       tx_rx_data_pin_i,
   input wire logic       tx_rx_data_pin_float_i,
   input wire logic       tx_rx_data_pin_o,
   input wire logic       tx_rx_data_pin_oe_o,
   input wire logic       transmit_mode_i,
   input wire logic       rx_data_i,
   input wire logic       pll_lock_i,
   // analogue controls
   input txmc_amp_t       amp_o,
   input txmc_freq_t      freq_o,
   input wire logic       modclk_tick_o,
   input wire logic       mod_charging_o,
   input wire logic       mod_discharging_o,
   input wire logic [1:0] mod_step_o,
   input wire logic [1:0] mod_current_weight_o,
   input wire logic       mod_select_illegal_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_pa_off_zero: assert property (amp_o.pa_on == (amp_o.pa_level != 3'h0))
      else $error("amplifier on state disagrees with level");
   a_max_power_one: assert property (amp_o.max_power == (amp_o.pa_level == 3'h1))
      else $error("maximum power flag disagrees with level");
   a_bypass_keeps_on: assert property (amp_o.pa_bypass && amp_o.pa_level != 3'h0 |-> amp_o.pa_on)
      else $error("bypass turned the amplifier off");
   a_illegal_mode_quiet: assert property (mod_select_illegal_o |-> freq_o == 4'h0)
      else $error("unused mode drives frequency controls");
   a_float_set_zero: assert property (tx_rx_data_pin_float_i [*6] |->
      !freq_o.use_set1 && !freq_o.shift_up && !freq_o.shift_down)
      else $error("floating pin did not select set zero");
   a_driven_no_lock: assert property (!tx_rx_data_pin_float_i [*6] |-> !freq_o.lock_lo)
      else $error("driven pin still locks to receive frequency");
   a_low_set_zero: assert property ((!tx_rx_data_pin_float_i && !tx_rx_data_pin_i) [*6] |->
      !freq_o.use_set1 && !freq_o.shift_up)
      else $error("low pin selected set one or shift up");
   a_high_goes_up: assert property ((!tx_rx_data_pin_float_i && tx_rx_data_pin_i) [*6] |->
      !freq_o.shift_down && (freq_o.use_set1 || freq_o.shift_up || mod_select_illegal_o))
      else $error("high pin did not raise frequency");
   a_pin_dir_rx: assert property (!transmit_mode_i |=>
      tx_rx_data_pin_oe_o && tx_rx_data_pin_o == $past(rx_data_i))
      else $error("data pin not driving receive data");
   a_pin_dir_tx: assert property (transmit_mode_i |=> !tx_rx_data_pin_oe_o && !tx_rx_data_pin_o)
      else $error("data pin driven during transmit");
   a_edge_start: assert property ($rose(mod_charging_o) || $rose(mod_discharging_o) |-> mod_step_o == 2'h0)
      else $error("edge did not start at first period");
   a_edge_four: assert property ($fell(mod_charging_o) || $fell(mod_discharging_o) |->
      $past(mod_step_o) == 2'h3)
      else $error("edge ended before fourth period");
   a_edge_weight: assert property (mod_charging_o || mod_discharging_o |->
      mod_current_weight_o == ((mod_step_o == 2'h0 || mod_step_o == 2'h3) ? 2'h1 : 2'h3))
      else $error("edge current weight wrong");

   c_rise: cover property ($rose(mod_charging_o));
   c_fall: cover property ($rose(mod_discharging_o));
   c_set1: cover property (freq_o.use_set1);
   c_illegal: cover property (mod_select_illegal_o);
endmodule

bind txmc_top txmc_top_props props_u (.core_clk_i, .reset_n_i, .ser_clk_i, .ser_latch_i,
   .ser_data_i, .ser_data_o, .ser_data_oe_o, .tx_rx_data_pin_i, .tx_rx_data_pin_float_i,
   .tx_rx_data_pin_o, .tx_rx_data_pin_oe_o, .transmit_mode_i, .rx_data_i, .pll_lock_i, .amp_o,
   .freq_o, .modclk_tick_o, .mod_charging_o, .mod_discharging_o, .mod_step_o,
   .mod_current_weight_o, .mod_select_illegal_o);

// >>> txmc_host_model.sv
`timescale 1ns/10ps
module txmc_host_model (
   // clock
   input wire logic clk_i,
   // serial port
   output logic     ser_clk_o,
   output logic     ser_latch_o,
   output logic     ser_data_o,
   input wire logic ser_data_i,
   // data pin
   output logic     pin_o,
   output logic     pin_float_o
);
   logic       a_flag;
   logic       rw_q;
   logic [7:0] rd_q;

   initial begin
      ser_clk_o = 1'b0;
      ser_latch_o = 1'b0;
      ser_data_o = 1'b0;
      pin_o = 1'b0;
      pin_float_o = 1'b1;
      a_flag = 1'b0;
      rw_q = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask

   // levels held 5 clocks: the port needs at least 3 per level
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {a, rw_q, d};
      for (int i = 15; i >= 0; i--) begin
         ser_data_o = f[i];
         ser_clk_o = 1'b0;
         cyc(5);
         // read bits stand by the end of each low phase
         rd_q = {rd_q[6:0], ser_data_i};
         ser_clk_o = 1'b1;
         cyc(5);
      end
      ser_clk_o = 1'b0;
      ser_data_o = ~ser_data_o;
      cyc(5);
      ser_latch_o = 1'b1;
      cyc(5);
      ser_latch_o = 1'b0;
      cyc(10);
   endtask

   // released pin sits at mid level; level line shows no stale value
   task automatic drive_pin(input logic flt, input logic lvl);
      pin_float_o = flt;
      pin_o = flt ? ~pin_o : lvl;
      cyc(6);
   endtask

   task automatic manchester(input logic b, output logic [1:0] w);
      w = b ? 2'b01 : 2'b10;
   endtask

   // one flag shared by both unbalanced inputs
   task automatic code_three_to_four_code(input logic [2:0] d, output logic [3:0] w);
      case (d)
         3'h0: w = a_flag ? 4'h4 : 4'hB;
         3'h1: w = 4'hC;
         3'h2: w = 4'h3;
         3'h3: w = 4'hA;
         3'h4: w = 4'h5;
         3'h5: w = 4'h9;
         3'h6: w = 4'h6;
         default: w = a_flag ? 4'h2 : 4'hD;
      endcase
      if (d == 3'h0 || d == 3'h7) a_flag = ~a_flag;
   endtask
endmodule

// >>> tx_modulation_control_tb.sv
`timescale 1ns/10ps
module tx_modulation_control_tb;
   import txmc_pkg::*;
   logic       core_clk_i = 1'b0;
   logic       reset_n_i, ser_clk_i, ser_latch_i, ser_data_i, ser_data_o, ser_data_oe_o;
   logic       tx_rx_data_pin_i, tx_rx_data_pin_float_i, tx_rx_data_pin_o, tx_rx_data_pin_oe_o;
   logic       transmit_mode_i, rx_data_i, pll_lock_i, modclk_tick_o, mod_select_illegal_o;
   logic       mod_charging_o, mod_discharging_o;
   logic [1:0] mod_step_o, mod_current_weight_o;
   txmc_amp_t  amp_o;
   txmc_freq_t freq_o;
   int         failures = 0;
   int         total_checks = 0;
   int         seed = 32'hD079;
   int         gap = 0;
   logic [5:0] seen_e = 6'h00;
   logic [12:0] obs;
   logic [25:0] obs_q[$];
   logic [31:0] per_q[$];
   logic [5:0] edge_q[$];

   txmc_top dut_u (.core_clk_i, .reset_n_i, .ser_clk_i, .ser_latch_i, .ser_data_i, .ser_data_o,
      .ser_data_oe_o, .tx_rx_data_pin_i, .tx_rx_data_pin_float_i, .tx_rx_data_pin_o,
      .tx_rx_data_pin_oe_o, .transmit_mode_i, .rx_data_i, .pll_lock_i, .amp_o, .freq_o,
      .modclk_tick_o, .mod_charging_o, .mod_discharging_o, .mod_step_o, .mod_current_weight_o,
      .mod_select_illegal_o);
   txmc_host_model host_u (.clk_i(core_clk_i), .ser_clk_o(ser_clk_i), .ser_latch_o(ser_latch_i),
      .ser_data_o(ser_data_i), .ser_data_i(ser_data_o), .pin_o(tx_rx_data_pin_i),
      .pin_float_o(tx_rx_data_pin_float_i));

   assign obs = {amp_o, freq_o, mod_select_illegal_o, tx_rx_data_pin_oe_o, tx_rx_data_pin_o};
   always #12.5 core_clk_i = ~core_clk_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic note(input logic [12:0] m, input logic [12:0] v);
      obs_q.push_back({m, v});
   endtask

   task automatic wait_tick;
      int n;
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (modclk_tick_o !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         failures++;
         summarize;
      end
      host_u.cyc(1);
   endtask

   // sent in modulator mode with the modulator clock still stopped; all four frequency controls are checked
   task automatic send(input logic [3:0] w, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         host_u.drive_pin(1'b0, w[k]);
         note(13'h0078, {6'h0, 2'b00, w[k], !w[k], 3'h0});
      end
   endtask

   always @(negedge core_clk_i) begin
      logic [25:0] e;
      while (obs_q.size() > 0) begin
         e = obs_q.pop_front();
         check(32'(obs & e[25:13]), 32'(e[12:0]));
      end
   end

   always @(negedge core_clk_i) begin
      gap++;
      if (modclk_tick_o === 1'b1) begin
         if (per_q.size() > 0) check(gap, per_q.pop_front());
         gap = 0;
      end
   end

   always @(negedge core_clk_i) begin
      if (mod_charging_o === 1'b1 || mod_discharging_o === 1'b1)
         seen_e = seen_e | {mod_charging_o, mod_discharging_o, 4'h1 << mod_step_o};
      else if (seen_e != 6'h00) begin
         if (edge_q.size() > 0) check(32'(seen_e), 32'(edge_q.pop_front()));
         seen_e = 6'h00;
      end
   end

   initial begin
      logic [1:0] pins [5];
      logic [2:0] dl [10];
      logic [3:0] ew [10];
      logic [3:0] w;
      logic [1:0] mw;
      logic       f, l;
      pins = '{2'b10, 2'b01, 2'b00, 2'b01, 2'b10};
      dl = '{3'h0, 3'h0, 3'h7, 3'h7, 3'h2, 3'h6, 3'h1, 3'h3, 3'h4, 3'h5};
      ew = '{4'hB, 4'h4, 4'hD, 4'h2, 4'h3, 4'h6, 4'hC, 4'hA, 4'h5, 4'h9};
      {reset_n_i, transmit_mode_i, rx_data_i, pll_lock_i} = 4'h4;
      repeat (6) @(posedge core_clk_i);
      #2 reset_n_i = 1'b1;
      host_u.cyc(4);
      note(13'h1FFF, 13'h0020);
      for (int b = 0; b < 2; b++) begin
         host_u.write_reg(7'h02, 8'(b << 4));
         for (int v = 0; v < 8; v++) begin
            host_u.write_reg(7'h00, 8'(v << 4));
            note(13'h1F80, {v != 0, b[0], v[2:0], v == 1, 7'h0});
         end
      end
      host_u.rw_q = 1'b1;
      host_u.write_reg(7'h00, 8'h00);
      host_u.rw_q = 1'b0;
      check(32'(host_u.rd_q), 32'h70);
      for (int m = 0; m < 4; m++) begin
         host_u.write_reg(7'h01, 8'(m << 6));
         note(13'h007C, {6'h0, (m == 0) ? 4'h4 : 4'h0, m[0], 2'h0});
      end
      pll_lock_i = 1'b1;
      for (int md = 0; md < 2; md++) begin
         host_u.write_reg(7'h01, md ? 8'h00 : 8'h80);
         for (int i = 0; i < 5; i++) begin
            {f, l} = pins[i];
            host_u.drive_pin(f, l);
            note(13'h0078, {6'h0, md ? (f ? 4'h4 : (l ? 4'h2 : 4'h1)) : {!f && l, 3'h0}, 3'h0});
         end
      end
      transmit_mode_i = 1'b0;
      for (int i = 0; i < 6; i++) begin
         {rx_data_i, pll_lock_i} = 2'($random(seed));
         host_u.cyc(3);
         note(13'h0003, {11'h0, 1'b1, rx_data_i});
      end
      transmit_mode_i = 1'b1;
      pll_lock_i = 1'b1;
      host_u.cyc(3);
      note(13'h0003, 13'h0000);
      for (int i = 0; i < 2; i++) begin
         host_u.manchester(i[0], mw);
         check(32'(mw), i ? 32'h1 : 32'h2);
         send({2'b00, mw}, 2);
      end
      for (int i = 0; i < 10; i++) begin
         host_u.code_three_to_four_code(dl[i], w);
         check(32'(w), 32'(ew[i]));
         send(w, 4);
      end
      host_u.write_reg(7'h07, 8'h03);
      for (int s = 0; s < 8; s++) begin
         host_u.write_reg(7'h06, 8'(s << 4));
         wait_tick;
         wait_tick;
         per_q.push_back(32'(3 << (7 - s)));
         wait_tick;
         wait_tick;
      end
      host_u.write_reg(7'h07, 8'h3F);
      wait_tick;
      per_q.push_back(32'd63);
      wait_tick;
      wait_tick;
      // levels held far beyond 8 modulator periods
      host_u.write_reg(7'h07, 8'h03);
      edge_q.push_back(6'h1F);
      host_u.drive_pin(1'b0, 1'b0);
      host_u.cyc(100);
      edge_q.push_back(6'h2F);
      host_u.drive_pin(1'b0, 1'b1);
      host_u.cyc(100);
      edge_q.push_back(6'h1F);
      host_u.drive_pin(1'b0, 1'b0);
      host_u.cyc(100);
      summarize;
   end
endmodule
